// *** logic/lslmc_link.v ***
`timescale 1ns/1ns
`default_nettype none
`include "lslmc_defs.vh"
module lslmc_link #(
    parameter [39:0] IDLE_CYC  = `LSLMC_IDLE_CYC,
    parameter [31:0] START_CYC = `LSLMC_START_CYC,
    parameter        DEPTH     = 8,
    parameter        AW        = 3
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // bus pin, open drain (oe low = pulling low)
    input  wire        i_lin_in,
    output wire        o_lin_out,
    output wire        o_lin_oe_n,
    output wire        o_term_en,
    // analog status, asynchronous
    input  wire        i_supply_ok,
    input  wire        i_supply_present,
    input  wire        i_overtemp,
    // protocol handler: response request and bytes
    input  wire        i_resp_req,
    input  wire        i_resp_valid,
    output wire        o_resp_ready,
    input  wire [7:0]  i_resp_data,
    input  wire        i_sleep_cmd,
    // status and timing to protocol handler
    output reg         o_awake,
    output reg         o_rx_enable,
    output reg         o_por,
    output reg         o_wake_event,
    output reg         o_sync_done,
    output reg  [19:0] o_bit_cycles,
    output reg         o_rx_bit,
    output reg         o_tx_busy
);
    ////////////////////////////////////////////////////////////
    localparam ST_SLEEP = 2'd0;
    localparam ST_WOKEN = 2'd1;
    localparam ST_START = 2'd2;
    localparam ST_RUN   = 2'd3;
    localparam integer WAKE_FULL = `LSLMC_WAKE_CYC;
    localparam integer GAP_FULL  = `LSLMC_FRAME_GAP_CYC;
    localparam [19:0]  WAKE_CYC  = WAKE_FULL[19:0];
    localparam [19:0]  GAP_CYC   = GAP_FULL[19:0];
    localparam [19:0] DEF_BIT  = 20'd9616;

    reg  [2:0]  s_lin;
    reg  [2:0]  s_ok;
    reg  [2:0]  s_pres;
    reg  [2:0]  s_ot;
    wire        lin;
    wire        lin_prev;
    wire        fall;
    wire        rise;
    reg  [1:0]  state;
    reg  [31:0] timer;
    reg  [39:0] idle_cnt;
    reg         blocked;
    reg         drv_off;
    reg         tx_low;
    wire        next_tx_high;

    // index 0 is never touched alone; index 2 is read only from s_lin
    always @(posedge i_clk) begin
        if (i_rst) begin
            s_lin  <= 3'h7;
            s_ok   <= 3'h0;
            s_pres <= 3'h0;
            s_ot   <= 3'h0;
        end else begin
            s_lin  <= {s_lin[1:0], i_lin_in};
            s_ok   <= {s_ok[1:0], i_supply_ok};
            s_pres <= {s_pres[1:0], i_supply_present};
            s_ot   <= {s_ot[1:0], i_overtemp};
        end
    end
    assign lin      = s_lin[1];
    assign lin_prev = s_lin[2];
    assign fall     = lin_prev & ~lin;
    assign rise     = ~lin_prev & lin;

    ////////////////////////////////////////////////////////////
    // mode control
    always @(posedge i_clk) begin
        if (i_rst) begin
            state        <= ST_SLEEP;
            timer        <= 32'h0;
            idle_cnt     <= 40'h0;
            o_awake      <= 1'b0;
            o_rx_enable  <= 1'b0;
            o_por        <= 1'b0;
            o_wake_event <= 1'b0;
        end else begin
            o_por        <= 1'b0;
            o_wake_event <= 1'b0;
            case (state)
                ST_SLEEP: begin
                    o_awake     <= 1'b0;
                    o_rx_enable <= 1'b0;
                    if (lin == `LSLMC_DOMINANT) begin
                        if (fall)
                            timer <= 32'h1;
                        else if (timer != 32'h0)
                            timer <= timer + 32'h1;
                        // strictly longer than the minimum: the count must pass it
                        if (timer[19:0] == WAKE_CYC) begin
                            state        <= ST_WOKEN;
                            o_wake_event <= 1'b1;
                        end
                    end else begin
                        timer <= 32'h0;
                    end
                end
                ST_WOKEN: begin
                    if (rise) begin
                        state   <= ST_START;
                        o_por   <= 1'b1;
                        o_awake <= 1'b1;
                        timer   <= 32'h0;
                    end
                end
                ST_START: begin
                    timer <= timer + 32'h1;
                    if (timer == START_CYC - 32'h1) begin
                        state    <= ST_RUN;
                        idle_cnt <= 40'h0;
                    end
                end
                ST_RUN: begin
                    o_rx_enable <= ~blocked;
                    if (lin == `LSLMC_DOMINANT)
                        idle_cnt <= 40'h0;
                    else
                        idle_cnt <= idle_cnt + 40'h1;
                    if (i_sleep_cmd || idle_cnt == IDLE_CYC - 40'h1) begin
                        state       <= ST_SLEEP;
                        o_rx_enable <= 1'b0;
                        o_awake     <= 1'b0;
                        timer       <= 32'h0;
                    end
                end
                default: state <= ST_SLEEP;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // supply and thermal guards
    always @(posedge i_clk) begin
        if (i_rst) begin
            blocked <= 1'b1;
            drv_off <= 1'b0;
        end else begin
            blocked <= ~s_ok[1];
            if (s_ot[1])
                drv_off <= 1'b1;
            // re-enable only as our own bit goes recessive, never inside a bit
            else if (drv_off && tx_low && next_tx_high)
                drv_off <= 1'b0;
        end
    end
    // termination follows awake; unpowered chip floats the pin
    assign o_term_en = s_pres[1] & o_awake;

    ////////////////////////////////////////////////////////////
    // sync field measurement: 8 bit times between 5 falling edges
    reg  [2:0]  edge_cnt;
    reg  [22:0] sync_cnt;
    reg         sync_run;
    reg  [19:0] gap_cnt;
    always @(posedge i_clk) begin
        if (i_rst) begin
            edge_cnt     <= 3'h0;
            sync_cnt     <= 23'h0;
            sync_run     <= 1'b0;
            gap_cnt      <= 20'h0;
            o_sync_done  <= 1'b0;
            o_bit_cycles <= DEF_BIT;
            o_rx_bit     <= 1'b1;
        end else begin
            o_rx_bit <= lin;
            // a long recessive gap closes the frame and drops a partial sync count; o_sync_done still holds
            if (lin == `LSLMC_DOMINANT || o_tx_busy)
                gap_cnt <= 20'h0;
            else if (gap_cnt != GAP_CYC)
                gap_cnt <= gap_cnt + 20'h1;
            if (!o_rx_enable || gap_cnt == GAP_CYC) begin
                edge_cnt <= 3'h0;
                sync_run <= 1'b0;
                if (!o_rx_enable)
                    o_sync_done <= 1'b0;
            end else if (!o_sync_done && fall && !o_tx_busy) begin
                // span runs across the inner edges; eight bits average out edge jitter
                edge_cnt <= edge_cnt + 3'h1;
                sync_run <= 1'b1;
                sync_cnt <= sync_cnt + 23'h1;
                if (edge_cnt == 3'h5) begin
                    o_bit_cycles <= sync_cnt[22:3];
                    o_sync_done  <= 1'b1;
                    sync_run     <= 1'b0;
                    edge_cnt     <= 3'h0;
                end
            end else if (sync_run) begin
                sync_cnt <= sync_cnt + 23'h1;
            end
            // second fall is the sync start bit; it counts as the first cycle
            if (edge_cnt == 3'h1 && fall)
                sync_cnt <= 23'h1;
        end
    end

    ////////////////////////////////////////////////////////////
    // response transmitter, bytes buffered from handler registers
    wire        fifo_valid;
    reg         fifo_ready;
    wire [7:0]  fifo_data;
    reg  [9:0]  shift;
    reg  [3:0]  bit_idx;
    reg  [19:0] bit_cnt;
    wire        tx_allowed;

    lslmc_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_in_valid  (i_resp_valid),
        .o_in_ready  (o_resp_ready),
        .i_in_data   (i_resp_data),
        .o_out_valid (fifo_valid),
        .i_out_ready (fifo_ready),
        .o_out_data  (fifo_data)
    );

    // transmit only on a slave-answer header, after sync, when not blocked
    assign tx_allowed   = i_resp_req & o_sync_done & o_rx_enable;
    assign next_tx_high = o_tx_busy & (bit_cnt == o_bit_cycles - 20'h1) & shift[1];

    always @* begin
        fifo_ready = tx_allowed & ~o_tx_busy;
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            shift     <= 10'h3FF;
            bit_idx   <= 4'h0;
            bit_cnt   <= 20'h0;
            o_tx_busy <= 1'b0;
            tx_low    <= 1'b0;
        end else if (!o_tx_busy) begin
            tx_low <= 1'b0;
            if (fifo_ready && fifo_valid) begin
                shift     <= {1'b1, fifo_data, 1'b0};
                bit_idx   <= 4'h0;
                bit_cnt   <= 20'h0;
                o_tx_busy <= 1'b1;
                tx_low    <= 1'b1;
            end
        // undervoltage cuts a byte short rather than risk a stuck dominant
        end else if (blocked) begin
            o_tx_busy <= 1'b0;
            tx_low    <= 1'b0;
            shift     <= 10'h3FF;
        end else if (bit_cnt == o_bit_cycles - 20'h1) begin
            bit_cnt <= 20'h0;
            shift   <= {1'b1, shift[9:1]};
            tx_low  <= ~shift[1];
            bit_idx <= bit_idx + 4'h1;
            if (bit_idx == 4'h9)
                o_tx_busy <= 1'b0;
        end else begin
            bit_cnt <= bit_cnt + 20'h1;
        end
    end

    // pin released unless actively sending dominant
    assign o_lin_out  = `LSLMC_DOMINANT;
    assign o_lin_oe_n = ~(o_tx_busy & ~shift[0] & ~drv_off & ~blocked & s_pres[1]);
endmodule // lslmc_link
`default_nettype wire

// *** logic/lslmc_defs.vh ***
`ifndef LSLMC_DEFS_VH
`define LSLMC_DEFS_VH
// bus levels
`define LSLMC_DOMINANT        1'b0
`define LSLMC_RECESSIVE       1'b1
// timing, printed units
`define LSLMC_CLK_MHZ         100
`define LSLMC_WAKE_MIN_US     30
`define LSLMC_WAKE_MAX_US     150
`define LSLMC_START_MS        5
`define LSLMC_IDLE_MIN_S      4
`define LSLMC_IDLE_TYP_S      8
`define LSLMC_IDLE_MAX_S      10
`define LSLMC_MAX_KBPS        10
`define LSLMC_TOL_PCT         2
// derived cycle counts (wake threshold above min: longer-than rounds up)
`define LSLMC_WAKE_CYC        (`LSLMC_WAKE_MIN_US * `LSLMC_CLK_MHZ + 1)
`define LSLMC_START_CYC       (`LSLMC_START_MS * 1000 * `LSLMC_CLK_MHZ)
`define LSLMC_IDLE_CYC        (40'd`LSLMC_IDLE_TYP_S * 40'd1000000 * `LSLMC_CLK_MHZ)
// sync field: 8 bit times from first falling edge to last falling edge
`define LSLMC_SYNC_BITS       8
`define LSLMC_FRAME_GAP_CYC   (11 * 1000 * `LSLMC_CLK_MHZ / `LSLMC_MAX_KBPS)
`endif

// *** logic/lslmc_fifo.v ***
`timescale 1ns/1ns
`default_nettype none
module lslmc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             i_clk,
    input  wire             i_rst,
    // fill side
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    // drain side
    output wire             o_out_valid,
    input  wire             i_out_ready,
    output reg  [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    reg             out_full;
    wire            push;
    wire            pop;
    wire            load;
    wire [AW:0]     total;

    // the output register is a slot too, so full means DEPTH words in all
    assign total       = count + {{AW{1'b0}}, out_full};
    assign o_in_ready  = (total != DEPTH[AW:0]);
    assign o_out_valid = out_full;
    assign push        = i_in_valid & o_in_ready;
    assign load        = (count != {(AW+1){1'b0}}) & (~out_full | i_out_ready);
    assign pop         = load;

    always @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr     <= {AW{1'b0}};
            rd_ptr     <= {AW{1'b0}};
            count      <= {(AW+1){1'b0}};
            out_full   <= 1'b0;
            o_out_data <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                mem[wr_ptr] <= i_in_data;
                wr_ptr      <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                o_out_data <= mem[rd_ptr];
                rd_ptr     <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
                out_full   <= 1'b1;
            end else if (i_out_ready) begin
                out_full <= 1'b0;
            end
            if (push & ~pop)
                count <= count + {{AW{1'b0}}, 1'b1};
            else if (pop & ~push)
                count <= count - {{AW{1'b0}}, 1'b1};
        end
    end
endmodule // lslmc_fifo
`default_nettype wire

// *** dv/lslmc_link_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module lslmc_link_checker #(
    parameter [39:0] IDLE_CYC  = 40'd2000,
    parameter [31:0] START_CYC = 32'd100
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // watched ports
    input wire logic o_lin_oe_n,
    input wire logic o_term_en,
    input wire logic i_supply_ok,
    input wire logic i_supply_present,
    input wire logic i_overtemp,
    input wire logic o_awake,
    input wire logic o_rx_enable,
    input wire logic o_por,
    input wire logic o_wake_event,
    input wire logic o_rx_bit,
    input wire logic o_tx_busy
);
default clocking cb @(posedge i_clk); endclocking
default disable iff (i_rst);
logic [39:0] idle_cnt;
logic [31:0] por_cnt;
// counters saturate so a long run never wraps into a false pass
always_ff @(posedge i_clk) begin
    if (i_rst || !o_awake || !o_rx_enable || !o_rx_bit) idle_cnt <= 40'h0;
    else if (idle_cnt != 40'hFFFFFFFFFF) idle_cnt <= idle_cnt + 40'h1;
    if (i_rst || o_por) por_cnt <= 32'h0;
    else if (por_cnt != 32'hFFFFFFFF) por_cnt <= por_cnt + 32'h1;
end
////////////////////////////////////////////////////////////////////////////////
sleep_quiet_a: assert property (!o_awake |-> o_lin_oe_n) else $error("driver on while asleep");
drive_busy_a: assert property (!o_lin_oe_n |-> o_tx_busy) else $error("bus driven outside a byte");
hot_off_a: assert property (i_overtemp [*4] |-> o_lin_oe_n) else $error("driver on while hot");
uv_block_a: assert property (!i_supply_ok [*5] |-> o_lin_oe_n && !o_rx_enable)
    else $error("traffic in undervoltage");
uv_term_a: assert property ((o_awake && i_supply_present) [*4] |-> o_term_en)
    else $error("termination off while supplied");
unpowered_a: assert property (!i_supply_present [*4] |-> !o_term_en) else $error("termination on unpowered");
wake_dom_a: assert property (o_wake_event |-> !o_rx_bit && !o_awake) else $error("wake without dominant");
por_rise_a: assert property (o_por |-> o_rx_bit ##1 o_awake) else $error("reset start not on rise");
start_wait_a: assert property ($rose(o_rx_enable) |-> por_cnt >= START_CYC - 32'd2)
    else $error("frames enabled too early");
idle_sleep_a: assert property (idle_cnt <= IDLE_CYC + 40'd4) else $error("idle too long awake");
endmodule // lslmc_link_checker
bind lslmc_link lslmc_link_checker #(.IDLE_CYC(IDLE_CYC), .START_CYC(START_CYC)) chk (
    .i_clk(i_clk), .i_rst(i_rst), .o_lin_oe_n(o_lin_oe_n), .o_term_en(o_term_en),
    .i_supply_ok(i_supply_ok), .i_supply_present(i_supply_present), .i_overtemp(i_overtemp),
    .o_awake(o_awake), .o_rx_enable(o_rx_enable), .o_por(o_por), .o_wake_event(o_wake_event),
    .o_rx_bit(o_rx_bit), .o_tx_busy(o_tx_busy));
`default_nettype wire

// *** dv/lslmc_master.sv ***
`timescale 1ns/1ns
`default_nettype none
module lslmc_master #(
    parameter int BIT = 100
) (
    input  wire logic i_clk,
    output var  logic o_drive_low
);
initial o_drive_low = 1'b0;
// changes only at the falling edge so the slave never samples a moving pin
task automatic hold(input logic low, input int n);
    o_drive_low = low;
    // bit time is scaled down for short runs; a real master keeps under the rate ceiling
    repeat (n) @(negedge i_clk);
endtask
task automatic send_byte(input logic [7:0] b);
    int k;
    hold(1'b1, BIT);
    for (k = 0; k < 8; k++) hold(!b[k], BIT);
    hold(1'b0, BIT);
endtask
// every frame opens with a header from this side
task automatic header(input logic [7:0] pid);
    hold(1'b1, 13 * BIT);
    hold(1'b0, BIT);
    send_byte(8'h55);
    send_byte(pid);
endtask
endmodule // lslmc_master
`default_nettype wire

// *** dv/lslmc_link_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module lslmc_link_tb;
localparam int BIT = 100;
logic       i_clk = 1'b0;
logic       i_rst = 1'b1;
logic       sup_ok = 1'b1, sup_pres = 1'b1, hot = 1'b0, req = 1'b0, vld = 1'b0;
logic [7:0] dat = 8'h00;
logic       por_seen = 1'b0, wake_seen = 1'b0, slp = 1'b0;
wire        m_low, lin_out, oe_n, term_en, ready, awake, rx_en, por, wake_ev, sync_done, rx_bit, busy;
wire [19:0] bitc;
// pull-up: released bus reads recessive
wire        bus = !(m_low || (!oe_n && !lin_out));
int         mismatches = 0, compares = 0, cycles = 0;
always #5 i_clk = ~i_clk;
lslmc_master #(.BIT(BIT)) M (.i_clk(i_clk), .o_drive_low(m_low));
lslmc_link #(.IDLE_CYC(40'd2000), .START_CYC(32'd100)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_lin_in(bus), .o_lin_out(lin_out), .o_lin_oe_n(oe_n),
    .o_term_en(term_en), .i_supply_ok(sup_ok), .i_supply_present(sup_pres), .i_overtemp(hot),
    .i_resp_req(req), .i_resp_valid(vld), .o_resp_ready(ready), .i_resp_data(dat), .i_sleep_cmd(slp),
    .o_awake(awake), .o_rx_enable(rx_en), .o_por(por), .o_wake_event(wake_ev), .o_sync_done(sync_done),
    .o_bit_cycles(bitc), .o_rx_bit(rx_bit), .o_tx_busy(busy));
////////////////////////////////////////////////////////////////////////////////
task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (por === 1'b1) por_seen <= 1'b1;
    if (wake_ev === 1'b1) wake_seen <= 1'b1;
    if (cycles == 40000) begin
        mismatches = mismatches + 1;
        finish_test();
    end
end
task automatic check(input string name, input logic [19:0] exp, input logic [19:0] got);
    compares++;
    if (got !== exp) begin
        mismatches++;
        $display("ERROR %s expected %h seen %h", name, exp, got);
    end
endtask
task automatic t_reset();
    check("oe_n", 20'h1, oe_n);
    check("awake", 20'h0, awake);
    check("bit_cycles", 20'h02590, bitc);
endtask
task automatic t_short();
    M.hold(1'b1, 1000);
    M.hold(1'b0, 500);
    check("short wake", 20'h0, wake_seen);
    check("short awake", 20'h0, awake);
endtask
task automatic t_wake();
    int n;
    M.hold(1'b1, 3100);
    check("wake event", 20'h1, wake_seen);
    check("awake before rise", 20'h0, awake);
    M.hold(1'b0, 10);
    check("por", 20'h1, por_seen);
    check("awake", 20'h1, awake);
    check("rx early", 20'h0, rx_en);
    for (n = 0; n < 200 && rx_en !== 1'b1; n++) @(negedge i_clk);
    check("start wait", 20'h1, n >= 80 && n <= 100);
endtask
task automatic t_resp();
    int k, j, low;
    M.header(8'h11);
    check("sync done", 20'h1, sync_done);
    check("bit within 2pct", 20'h1, bitc >= 20'd98 && bitc <= 20'd102);
    vld = 1'b1;
    for (k = 0; k < 8; k++) begin
        dat = 8'hA5 + 8'(k);
        check("ready", 20'h1, ready);
        @(negedge i_clk);
    end
    check("full refuses", 20'h0, ready);
    vld = 1'b0;
    repeat (50) @(negedge i_clk);
    check("no request no reply", 20'h1, oe_n);
    req = 1'b1;
    for (k = 0; k < 20 && busy !== 1'b1; k++) @(negedge i_clk);
    repeat (BIT / 2) @(negedge i_clk);
    for (j = 0; j < 10; j++) begin
        check("tx bit", (j == 0) ? 20'h0 : (j == 9) ? 20'h1 : 20'((8'hA5 >> (j - 1)) & 8'h01), bus);
        if (j == 9) hot = 1'b1;
        repeat (BIT) @(negedge i_clk);
    end
    low = 0;
    repeat (900) begin
        if (oe_n === 1'b0) low++;
        @(negedge i_clk);
    end
    check("hot receive only", 20'h0, 20'(low));
    hot = 1'b0;
    for (k = 0; k < 8000 && (busy !== 1'b0 || ready !== 1'b1 || k < 7000); k++) begin
        if (oe_n === 1'b0) low++;
        @(negedge i_clk);
    end
    check("driver back", 20'h1, low > 0);
    check("drained", 20'h1, ready);
    req = 1'b0;
endtask
task automatic t_uv();
    sup_ok = 1'b0;
    repeat (6) @(negedge i_clk);
    check("uv rx", 20'h0, rx_en);
    check("uv drive", 20'h1, oe_n);
    check("uv term", 20'h1, term_en);
    sup_ok = 1'b1;
    repeat (6) @(negedge i_clk);
    check("uv resume", 20'h1, rx_en);
    sup_pres = 1'b0;
    repeat (6) @(negedge i_clk);
    check("unpowered term", 20'h0, term_en);
    sup_pres = 1'b1;
endtask
task automatic t_idle();
    int n;
    M.hold(1'b1, 20);
    repeat (1500) @(negedge i_clk);
    M.hold(1'b1, 20);
    M.hold(1'b0, 1500);
    check("idle restart", 20'h1, awake);
    for (n = 0; n < 1000 && awake !== 1'b0; n++) @(negedge i_clk);
    check("idle sleep", 20'h0, awake);
endtask
task automatic t_sleep();
    int n;
    M.hold(1'b1, 3100);
    M.hold(1'b0, 10);
    for (n = 0; n < 200 && rx_en !== 1'b1; n++) @(negedge i_clk);
    check("rewake", 20'h1, awake);
    slp = 1'b1;
    @(negedge i_clk);
    slp = 1'b0;
    @(negedge i_clk);
    check("sleep command", 20'h0, awake);
endtask
initial begin
    repeat (6) @(negedge i_clk);
    i_rst = 1'b0;
    @(negedge i_clk);
    t_reset();
    t_short();
    t_wake();
    t_resp();
    t_uv();
    t_idle();
    t_sleep();
    finish_test();
end
endmodule // lslmc_link_tb
`default_nettype wire
